//--- hdl/sgc_pkg.sv
// package: constants, states and carriers of global control register zero
package sgc_pkg;

  // register map and serial management commands
  localparam logic [7:0]  GC0_ADDR     = 8'h02;
  localparam logic [7:0]  SPI_CMD_WR   = 8'h02;
  localparam logic [7:0]  SPI_CMD_RD   = 8'h03;
  localparam logic [2:0]  SPI_LAST_BIT = 3'h7;

  // field positions of global_control_zero
  localparam int          GC0_RSVD_BIT = 7;
  localparam int          PRI_HI       = 6;
  localparam int          PRI_LO       = 4;
  localparam int          PORT_EN_BIT  = 3;
  localparam int          SHARE_BIT    = 2;
  localparam int          CONF_BIT     = 1;
  localparam int          FAST_AGE_BIT = 0;

  // reset: threshold 0x4, port enabled (pull-up), sharing on, others 0
  localparam logic [7:0]  GC0_RESET    = 8'h4C;

  // frames dropped in conformance mode
  localparam logic [15:0] PAUSE_TYPE   = 16'h8808;
  localparam logic [47:0] PAUSE_DA     = 48'h0180C2000001;

  // fixed-allocation share: one fifth of the pool per port
  localparam int          BUF_SHARE_DIV = 5;

  // timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_US         = 1000;
  localparam int          TICK_CYC        = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int          NORMAL_AGE_S    = 300;
  localparam int          NORMAL_AGE_TICK = NORMAL_AGE_S * 1000000 / TICK_US;
  localparam logic [1:0]  STRAP_WAIT      = 2'h3;

  // serial port byte phases
  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } sgc_spi_state_e;

  // tagged frame priority query
  typedef struct packed {
    logic       valid;
    logic [2:0] user_pri;
  } sgc_tag_s;

  // received frame header for the drop filter
  typedef struct packed {
    logic        valid;
    logic        flow_ctrl;
    logic [15:0] type_len;
    logic [47:0] dest_addr;
  } sgc_frame_hdr_s;

  // outputs of the second media port
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
  } sgc_mii_out_s;

endpackage : sgc_pkg

//--- hdl/sgc_age_sched.sv
// module: aging period scheduler with fast aging on link loss
`timescale 1ns/10ps
module sgc_age_sched
  import sgc_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYC,
  parameter int NORMAL_TICKS = NORMAL_AGE_TICK
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // requests and table handshake
  input  wire logic fast_req,
  input  wire logic sweep_done,
  // schedule outputs
  output logic      sweep_start,
  output logic      fast_active
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int AGE_W  = $clog2(NORMAL_TICKS + 1);

  if (TICK_CYCLES < 1 || NORMAL_TICKS < 1)
  begin : g_bad
    $error("aging counts must be at least one");
  end

  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  logic [AGE_W-1:0]  age_cnt_q;
  logic              sweep_q;
  logic              fast_q;

  //////////////////////////////////////////////////////////////////////////
  // millisecond enable, keeps the long period inside 32 bits
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sweep scheduling: fast pass at once, then back to the normal period
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      age_cnt_q <= '0;
      sweep_q   <= 1'b0;
      fast_q    <= 1'b0;
    end
    else
    begin
      sweep_q <= 1'b0;
      if (fast_req && !fast_q)
      begin
        fast_q    <= 1'b1;
        sweep_q   <= !sweep_q; // a sweep begun a cycle ago serves
        age_cnt_q <= '0;
      end
      else if (fast_q)
      begin
        if (sweep_done)
        begin
          fast_q    <= 1'b0;
          age_cnt_q <= '0;
        end
      end
      else if (tick_q)
      begin
        if (age_cnt_q == AGE_W'(NORMAL_TICKS - 1))
        begin
          age_cnt_q <= '0;
          sweep_q   <= 1'b1;
        end
        else
        begin
          age_cnt_q <= age_cnt_q + 1'b1;
        end
      end
    end
  end

  assign sweep_start = sweep_q;
  assign fast_active = fast_q;

endmodule : sgc_age_sched

//--- hdl/sgc_global_control_zero.sv
// module: global control register zero with serial access and its effects
`timescale 1ns/10ps

module sgc_global_control_zero
  import sgc_pkg::*;
#(
  parameter int NUM_PORTS    = 5,
  parameter int BUF_TOTAL    = 512,
  parameter int CNT_W        = 10,
  parameter int TICK_CYCLES  = TICK_CYC,
  parameter int NORMAL_TICKS = NORMAL_AGE_TICK
)
(
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  // serial management slave pins
  input  wire logic                           spis_n,
  input  wire logic                           spic,
  input  wire logic                           spid,
  output logic                                spiq_o,
  output logic                                spiq_oe,
  // strap
  input  wire logic                           port_enable_strap_pin,
  // priority classification
  input  wire sgc_tag_s                       tag_in,
  output logic                                pri_valid,
  output logic                                pri_high,
  // receive drop filter
  input  wire sgc_frame_hdr_s                 frame_hdr,
  output logic                                drop_valid,
  output logic                                drop_frame,
  // second media port
  input  wire sgc_mii_out_s                   second_media_port_core,
  output sgc_mii_out_s                        second_media_port_o,
  output logic                                second_media_port_oe,
  // frame buffer allocation
  input  wire logic [NUM_PORTS-1:0][CNT_W-1:0] port_buf_used,
  input  wire logic [CNT_W-1:0]               buf_free_cnt,
  output logic [NUM_PORTS-1:0]                buf_grant,
  // links and address table aging
  input  wire logic [NUM_PORTS-1:0]           link_up,
  input  wire logic                           age_sweep_done,
  output logic                                age_sweep_start,
  output logic                                fast_aging,
  output logic                                flush_all
);

  localparam logic [CNT_W-1:0] PORT_QUOTA = CNT_W'(BUF_TOTAL / BUF_SHARE_DIV);

  if (NUM_PORTS < 1 || BUF_TOTAL < BUF_SHARE_DIV ||
      BUF_TOTAL >= (1 << CNT_W))
  begin : g_bad
    $error("port count or buffer pool size not servable");
  end

  // register and serial state
  logic [7:0]       gc0_q;
  logic [2:0]       spis_s_q;
  logic [2:0]       spic_s_q;
  logic [2:0]       spid_s_q;
  logic [2:0]       strap_s_q;
  logic [1:0]       strap_cnt_q;
  logic             strap_done_q;
  sgc_spi_state_e   state_q;
  logic [2:0]       bit_cnt_q;
  logic [6:0]       rx_q;
  logic [7:0]       addr_q;
  logic             cmd_wr_q;
  logic             cmd_rd_q;
  logic [7:0]       tx_q;
  logic             spiq_q;
  logic             spiq_oe_q;
  // function outputs
  logic             pri_valid_q;
  logic             pri_high_q;
  logic             drop_valid_q;
  logic             drop_q;
  sgc_mii_out_s     mii_q;
  logic             mii_oe_q;
  logic [NUM_PORTS-1:0] grant_q;
  logic [NUM_PORTS-1:0] link_q;
  logic             flush_q;
  // combinational
  logic             sel;
  logic             rise;
  logic             fall;
  logic             byte_done;
  logic [7:0]       rx_byte;
  logic             wr_stb;
  logic [7:0]       next_addr;
  logic [NUM_PORTS-1:0] link_fall;

  // read mux: only this register is mapped, others read as zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input logic [7:0] v);
    rd_reg = (a == GC0_ADDR) ? v : 8'h00;
  endfunction : rd_reg

  //////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      spis_s_q  <= 3'h7;
      spic_s_q  <= 3'h0;
      spid_s_q  <= 3'h0;
      strap_s_q <= 3'h7;
    end
    else
    begin
      spis_s_q  <= {spis_s_q[1:0], spis_n};
      spic_s_q  <= {spic_s_q[1:0], spic};
      spid_s_q  <= {spid_s_q[1:0], spid};
      strap_s_q <= {strap_s_q[1:0], port_enable_strap_pin};
    end
  end

  // edges count while stage 1 holds the new level and stage 2 still the old one
  assign sel       = !spis_s_q[1] && !spis_s_q[2];
  assign rise      = sel && spic_s_q[1] && !spic_s_q[2];
  assign fall      = sel && !spic_s_q[1] && spic_s_q[2];
  assign byte_done = rise && (bit_cnt_q == SPI_LAST_BIT);
  assign rx_byte   = {rx_q, spid_s_q[1]};
  assign next_addr = (state_q == ST_ADDR) ? rx_byte : addr_q + 8'h01;
  assign wr_stb    = byte_done && (state_q == ST_DATA) && cmd_wr_q &&
                     (addr_q == GC0_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // serial byte framing: command, address, then data bytes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= ST_CMD;
      bit_cnt_q <= 3'h0;
      rx_q      <= 7'h00;
      addr_q    <= 8'h00;
      cmd_wr_q  <= 1'b0;
      cmd_rd_q  <= 1'b0;
    end
    else if (!sel)
    begin
      state_q   <= ST_CMD;
      bit_cnt_q <= 3'h0;
    end
    else if (rise)
    begin
      rx_q      <= rx_byte[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done)
      begin
        unique case (state_q)
          ST_CMD:
          begin
            cmd_wr_q <= (rx_byte == SPI_CMD_WR);
            cmd_rd_q <= (rx_byte == SPI_CMD_RD);
            state_q  <= ST_ADDR;
          end
          ST_ADDR:
          begin
            addr_q  <= rx_byte;
            state_q <= ST_DATA;
          end
          ST_DATA:
          begin
            addr_q <= next_addr; // burst walks up the map
          end
          default:
          begin
            state_q <= ST_CMD;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read shifter: loaded on the last rising edge, shifted on falling edges
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_q   <= 8'h00;
      spiq_q <= 1'b0;
    end
    else if (byte_done && (state_q != ST_CMD))
    begin
      tx_q <= cmd_rd_q ? rd_reg(next_addr, gc0_q) : 8'h00;
    end
    else if (fall)
    begin
      spiq_q <= tx_q[7];
      tx_q   <= {tx_q[6:0], 1'b0};
    end
  end

  // data pin driven only while selected for a read
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      spiq_oe_q <= 1'b0;
    else
      spiq_oe_q <= sel && cmd_rd_q && (state_q == ST_DATA);
  end

  //////////////////////////////////////////////////////////////////////////
  // strap capture: waits for the synchroniser to fill after reset release
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_cnt_q  <= strap_cnt_q + 2'h1;
      strap_done_q <= (strap_cnt_q == STRAP_WAIT);
    end
  end

  // the register; a software write beats the one-time strap load
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      gc0_q <= GC0_RESET;
    else if (wr_stb)
      gc0_q <= rx_byte; // bit 7 stored, unused
    else if (!strap_done_q && (strap_cnt_q == STRAP_WAIT))
      gc0_q[PORT_EN_BIT] <= strap_s_q[2];
  end

  //////////////////////////////////////////////////////////////////////////
  // priority classification against the threshold
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pri_valid_q <= 1'b0;
      pri_high_q  <= 1'b0;
    end
    else
    begin
      pri_valid_q <= tag_in.valid;
      pri_high_q  <= tag_in.valid &&
                     (tag_in.user_pri >= gc0_q[PRI_HI:PRI_LO]);
    end
  end

  // receive drop filter
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drop_valid_q <= 1'b0;
      drop_q       <= 1'b0;
    end
    else
    begin
      drop_valid_q <= frame_hdr.valid;
      if (gc0_q[CONF_BIT])
        drop_q <= frame_hdr.valid &&
                  ((frame_hdr.type_len == PAUSE_TYPE) ||
                   (frame_hdr.dest_addr == PAUSE_DA));
      else
        drop_q <= frame_hdr.valid && frame_hdr.flow_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // second media port: outputs pass when enabled, else released
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mii_q    <= '0;
      mii_oe_q <= 1'b0;
    end
    else
    begin
      mii_q    <= gc0_q[PORT_EN_BIT] ? second_media_port_core : '0;
      mii_oe_q <= gc0_q[PORT_EN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-port buffer grant; shared mode only needs free space in the pool
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_grant
    always_ff @(posedge mclk or negedge arst_n)
    begin
      if (!arst_n)
        grant_q[p] <= 1'b0;
      else if (gc0_q[SHARE_BIT])
        grant_q[p] <= (buf_free_cnt != '0);
      else
        grant_q[p] <= (buf_free_cnt != '0) &&
                      (port_buf_used[p] < PORT_QUOTA);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link loss detection; links come from same-clock port logic
  assign link_fall = link_q & ~link_up;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_q  <= '0;
      flush_q <= 1'b0;
    end
    else
    begin
      link_q  <= link_up;
      flush_q <= |link_fall;
    end
  end

  // aging scheduler; fast pass only when armed
  sgc_age_sched #(
    .TICK_CYCLES  (TICK_CYCLES),
    .NORMAL_TICKS (NORMAL_TICKS)
  ) u_age (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .fast_req    ((|link_fall) && gc0_q[FAST_AGE_BIT]),
    .sweep_done  (age_sweep_done),
    .sweep_start (age_sweep_start),
    .fast_active (fast_aging)
  );

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign spiq_o               = spiq_q;
  assign spiq_oe              = spiq_oe_q;
  assign pri_valid            = pri_valid_q;
  assign pri_high             = pri_high_q;
  assign drop_valid           = drop_valid_q;
  assign drop_frame           = drop_q;
  assign second_media_port_o  = mii_q;
  assign second_media_port_oe = mii_oe_q;
  assign buf_grant            = grant_q;
  assign flush_all            = flush_q;

endmodule : sgc_global_control_zero

//--- tb/sgc_gc0_checker.sv
// checker: port-level properties of global control register zero
`timescale 1ns/10ps
module sgc_gc0_checker
  import sgc_pkg::*;
#(
  parameter int NUM_PORTS = 5,
  parameter int CNT_W     = 10
)
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 arst_n,
  // serial port
  input wire logic                 spis_n,
  input wire logic                 spiq_oe,
  // queries
  input wire sgc_tag_s             tag_in,
  input wire logic                 pri_valid,
  input wire logic                 pri_high,
  input wire sgc_frame_hdr_s       frame_hdr,
  input wire logic                 drop_valid,
  input wire logic                 drop_frame,
  // second media port and buffers
  input wire sgc_mii_out_s         second_media_port_o,
  input wire logic                 second_media_port_oe,
  input wire logic [CNT_W-1:0]     buf_free_cnt,
  input wire logic [NUM_PORTS-1:0] buf_grant,
  // links and aging
  input wire logic [NUM_PORTS-1:0] link_up,
  input wire logic                 age_sweep_done,
  input wire logic                 age_sweep_start,
  input wire logic                 fast_aging,
  input wire logic                 flush_all
);
  logic [NUM_PORTS-1:0] link_q;
  logic                 link_fall;

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // link history, reset low so no fall is seen right after reset
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      link_q <= '0;
    else
      link_q <= link_up;
  assign link_fall = |(link_q & ~link_up);

  ////////////////////////////////////////////////////////////////////////
  // priority 7 is at or above any threshold, so it is always high
  pri_top_a: assert property (tag_in.valid && tag_in.user_pri == 3'h7
    |=> pri_valid && pri_high) else $error("priority 7 not high");
  pri_idle_a: assert property (!tag_in.valid |=> !pri_valid)
    else $error("priority answer without query");
  // two quiet cycles guard against the disable edge itself
  port_quiet_a: assert property (!second_media_port_oe &&
    !$past(second_media_port_oe) |-> second_media_port_o == '0)
    else $error("second port drives while isolated");
  drop_plain_a: assert property (frame_hdr.valid && !frame_hdr.flow_ctrl
    && frame_hdr.type_len != PAUSE_TYPE && frame_hdr.dest_addr != PAUSE_DA
    |=> drop_valid && !drop_frame) else $error("plain frame dropped");
  grant_empty_a: assert property (buf_free_cnt == '0 |=> buf_grant == '0)
    else $error("grant with empty pool");
  flush_link_a: assert property (flush_all == $past(link_fall))
    else $error("flush not tied to link loss");
  fast_end_a: assert property (fast_aging && age_sweep_done
    |=> !fast_aging) else $error("fast aging outlives sweep");
  spi_idle_a: assert property (spis_n [*4] |-> !spiq_oe)
    else $error("serial output driven while deselected");
  start_pulse_a: assert property (age_sweep_start |=> !age_sweep_start)
    else $error("sweep start longer than a pulse");

  // main scenarios reached
  cover property ($rose(fast_aging));
  cover property (drop_valid && drop_frame);
  cover property (pri_valid && pri_high);
  cover property (spiq_oe);
endmodule : sgc_gc0_checker

//--- tb/sgc_global_control_zero_test.sv
// testbench: serial access, queries, port isolation and aging
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module sgc_global_control_zero_test;
  import sgc_pkg::*;
  localparam int SHARE = 512 / BUF_SHARE_DIV;
  logic              mclk, arst_n, spis_n, spic, spid, spiq_o, spiq_oe;
  logic              strap, pri_valid, pri_high, drop_valid, drop_frame;
  logic              mo_oe, sdone, sstart, fast, flush;
  sgc_tag_s          tag;
  sgc_frame_hdr_s    hdr;
  sgc_mii_out_s      core, mo;
  logic [4:0][9:0]   used;
  logic [9:0]        free;
  logic [4:0]        grant, link;
  logic [7:0]        d;
  int                error_cnt, n_checks;

  // short aging counts keep the run brief
  sgc_global_control_zero #(.TICK_CYCLES(4), .NORMAL_TICKS(5))
  u_sgc_global_control_zero (
    .mclk(mclk), .arst_n(arst_n), .spis_n(spis_n), .spic(spic),
    .spid(spid), .spiq_o(spiq_o), .spiq_oe(spiq_oe),
    .port_enable_strap_pin(strap), .tag_in(tag), .pri_valid(pri_valid),
    .pri_high(pri_high), .frame_hdr(hdr), .drop_valid(drop_valid),
    .drop_frame(drop_frame), .second_media_port_core(core),
    .second_media_port_o(mo), .second_media_port_oe(mo_oe),
    .port_buf_used(used), .buf_free_cnt(free), .buf_grant(grant),
    .link_up(link), .age_sweep_done(sdone), .age_sweep_start(sstart),
    .fast_aging(fast), .flush_all(flush));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // inputs move 1 ns after the edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // phases of 6 cycles beat the 3-flop synchronizers with margin
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spic = 1'b0;
      spid = tx[i];
      cyc(6);
      rx[i] = spiq_o;
      spic = 1'b1;
      cyc(6);
    end
  endtask : spi_byte

  task automatic spi_xfer(input logic [7:0] c, a, v, output logic [7:0] q);
    logic [7:0] x;
    spis_n = 1'b0;
    cyc(4);
    spi_byte(c, x);
    spi_byte(a, x);
    spi_byte(v, q);
    spic = 1'b0;
    cyc(6);
    spis_n = 1'b1;
    cyc(8);
  endtask : spi_xfer

  task automatic wr(input logic [7:0] v);
    logic [7:0] x;
    spi_xfer(SPI_CMD_WR, GC0_ADDR, v, x);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    spi_xfer(SPI_CMD_RD, GC0_ADDR, 8'h00, d);
    `CHK("gc0 reset", 8'h4C, d)
    `CHK("port oe reset", 1'b1, mo_oe)
    wr(8'hB3);
    spi_xfer(SPI_CMD_WR, 8'h03, 8'h00, d);
    spi_xfer(SPI_CMD_RD, GC0_ADDR, 8'h00, d);
    `CHK("gc0 rw", 8'hB3, d)
    spi_xfer(SPI_CMD_RD, 8'h03, 8'h00, d);
    `CHK("unmapped read", 8'h00, d)
  endtask : t_regs

  task automatic t_pri_port;
    wr(8'h30);
    for (int p = 0; p < 8; p++)
    begin
      tag = '{1'b1, 3'(p)};
      cyc(1);
      `CHK("pri high", (p >= 3), pri_high)
    end
    tag.valid = 1'b0;
    `CHK("isolated oe", 1'b0, mo_oe)
    `CHK("isolated data", 8'h00, mo)
    wr(8'h38);
    `CHK("enabled oe", 1'b1, mo_oe)
    `CHK("enabled data", core, mo)
  endtask : t_pri_port

  task automatic drop_q(input logic f, input logic [15:0] t,
                        input logic [47:0] a, input logic e);
    hdr = '{1'b1, f, t, a};
    cyc(1);
    hdr.valid = 1'b0;
    `CHK("drop", e, drop_frame)
  endtask : drop_q

  task automatic t_drop_buf;
    wr(8'h02);
    drop_q(1'b0, PAUSE_TYPE, 48'h1, 1'b1);
    drop_q(1'b0, 16'h0800, PAUSE_DA, 1'b1);
    drop_q(1'b0, 16'h0800, 48'h1, 1'b0);
    wr(8'h00);
    drop_q(1'b1, 16'h0800, 48'h1, 1'b1);
    drop_q(1'b0, PAUSE_TYPE, PAUSE_DA, 1'b0);
    used[0] = 10'(SHARE - 1);
    used[1] = 10'(SHARE);
    free = 10'h064;
    cyc(1);
    `CHK("fixed grant", 5'h1D, grant)
    wr(8'h04);
    `CHK("shared grant", 5'h1F, grant)
    free = 10'h000;
    cyc(1);
    `CHK("empty grant", 5'h00, grant)
  endtask : t_drop_buf

  task automatic t_age;
    int n;
    wr(8'h01);
    link[2] = 1'b0;
    cyc(1);
    `CHK("flush", 1'b1, flush)
    for (int k = 0; k < 8 && fast !== 1'b1; k++)
      cyc(1);
    `CHK("fast start", 1'b1, fast)
    if (fast !== 1'b1)
      close_out();
    sdone = 1'b1;
    cyc(1);
    sdone = 1'b0;
    cyc(1);
    `CHK("fast end", 1'b0, fast)
    // next sweep after 5 ticks of 4 cycles, tick phase unknown: 16..19
    n = 0;
    while (sstart !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    `CHK("normal period", 1'b1, (n >= 16 && n <= 19))
    if (sstart !== 1'b1)
      close_out();
    link = 5'h1F;
    wr(8'h00);
    link[3] = 1'b0;
    cyc(1);
    `CHK("flush no fast", 1'b1, flush)
    cyc(6);
    `CHK("no fast pass", 1'b0, fast)
    link = 5'h1F;
  endtask : t_age

  // mid-run reset with the strap low: the second port comes up isolated
  task automatic t_strap;
    strap = 1'b0;
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(10);
    `CHK("strap isolate oe", 1'b0, mo_oe)
    spi_xfer(SPI_CMD_RD, GC0_ADDR, 8'h00, d);
    `CHK("gc0 strap low", 8'h44, d)
    strap = 1'b1;
  endtask : t_strap

  ////////////////////////////////////////////////////////////////////////
  // main sequence and hang limit
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    {arst_n, spis_n, spic, spid, strap} = 5'h0B;
    tag = '0;
    hdr = '0;
    core = 8'hB5;
    used = '0;
    free = 10'h064;
    link = 5'h1F;
    sdone = 1'b0;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'b1;
    cyc(10);
    t_regs();
    t_pri_port();
    t_drop_buf();
    t_age();
    t_strap();
    close_out();
  end

  initial
  begin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
endmodule : sgc_global_control_zero_test

bind sgc_global_control_zero sgc_gc0_checker #(
  .NUM_PORTS(NUM_PORTS), .CNT_W(CNT_W)) u_sgc_gc0_checker (
  .mclk(mclk), .arst_n(arst_n), .spis_n(spis_n), .spiq_oe(spiq_oe),
  .tag_in(tag_in), .pri_valid(pri_valid), .pri_high(pri_high),
  .frame_hdr(frame_hdr), .drop_valid(drop_valid), .drop_frame(drop_frame),
  .second_media_port_o(second_media_port_o),
  .second_media_port_oe(second_media_port_oe),
  .buf_free_cnt(buf_free_cnt), .buf_grant(buf_grant), .link_up(link_up),
  .age_sweep_done(age_sweep_done), .age_sweep_start(age_sweep_start),
  .fast_aging(fast_aging), .flush_all(flush_all));
